// File: bau_pkg.sv
// Purpose: Constants for the breakpoint address unit
// Assumes: Avalon-MM register bus, 32-bit words, byte addresses
// Notes: Register offsets are word aligned
package bau_pkg;
	localparam logic [4:0] OFF_STATUS_CONTROL = 5'h00;
	localparam logic [4:0] OFF_ADDR_HIGH = 5'h04;
	localparam logic [4:0] OFF_ADDR_LOW = 5'h08;
	localparam logic [4:0] OFF_AUXILIARY = 5'h0c;
	localparam logic [4:0] OFF_WAIT_STATUS = 5'h10;
	localparam logic [4:0] OFF_FLAG_CONTROL = 5'h14;
	localparam logic [4:0] OFF_IRQ_STATUS = 5'h18;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h1c;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_ACTIVE = 6;
	localparam int BIT_WDOG_OFF = 0;
	localparam int BIT_WAIT_EXIT = 1;
	localparam int BIT_FLAG_CLEAR = 7;
	localparam int IRQ_BREAK = 0;
	localparam int IRQ_RETURN = 1;
	localparam logic [7:0] SWI_OPCODE = 8'h83;
	localparam logic [15:0] VEC_NORMAL = 16'hfffc;
	localparam logic [15:0] VEC_MONITOR = 16'hfefc;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_PENDING = 3'b010,
		ST_BREAK = 3'b100
	} bau_state_e;
endpackage : bau_pkg

// File: bau_core.sv
// Purpose: Hardware breakpoint unit with Avalon-MM register access
// Assumes: One 100 MHz clock; CPU signals are on the same clock
// Notes: Waitrequest low one cycle after a request is seen
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Enabled address match of program counter requests a breakpoint
// - On break, force interrupt opcode and vector to normal or monitor address
// - Software writing one to break-active triggers a break
// - Match on opcode address stops that instruction before it runs
// - Match on operand address lets the instruction finish first
// - Software break is taken just before the next instruction
// - Return-from-interrupt ends the break state
// - Active bit clear with same address gives no further break
// - Peripheral flags clearable in break only with flag-clear bit set
// - Timer counter frozen while break is active
// - Watchdog off in monitor break when watchdog-off bit set; resets zero
// - Enable bit 7 gates address breaks; write zero or reset clears it
// - Active bit set on match, cleared on reset, software clears it
// - Two byte registers hold break address, reset to zero
// - Flag shows wait mode was exited by a break
// - No address break while in wait or stop mode; software breaks are still taken
module bau_core (
	input wire logic i_core_clk, // Bus clock
	input wire logic i_resetn, // Async reset, active low
	input wire logic [4:0] i_avs_address, // Byte address
	input wire logic i_avs_read, // Read strobe
	input wire logic i_avs_write, // Write strobe
	input wire logic [31:0] i_avs_writedata, // Write data
	input wire logic [3:0] i_avs_byteenable, // Byte lanes
	output logic [31:0] o_avs_readdata, // Read data
	output logic o_avs_waitrequest, // Stall
	input wire logic [15:0] i_cpu_addr, // CPU address bus
	input wire logic i_cpu_pc_fetch, // Address comes from program counter
	input wire logic i_cpu_opcode_fetch, // Fetch is an opcode
	input wire logic i_cpu_instr_start, // Next instruction begins this cycle
	input wire logic i_cpu_rti, // Return-from-interrupt executed
	input wire logic i_cpu_low_power, // Wait or stop mode
	input wire logic i_cpu_wait_wake, // Wait mode leaving this cycle
	input wire logic i_monitor_rom, // Monitor mode
	output logic o_breakpoint_request, // Request to integration unit
	output logic o_force_opcode, // Load instruction register with opcode
	output logic [7:0] o_opcode, // Opcode to load
	output logic [15:0] o_vector, // Break vector address
	output logic o_break_state, // Break state active
	output logic o_timer_freeze, // Hold timer counter
	output logic o_watchdog_off, // Disable watchdog
	output logic o_flag_clear_ok, // Peripheral flags may be cleared
	output logic o_irq // Interrupt
);
	logic [7:0] addr_high_reg;
	logic [7:0] addr_low_reg;
	logic enable_reg;
	logic active_reg;
	logic wdog_off_reg;
	logic wait_exit_reg;
	logic flag_clear_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic ack_reg;
	logic armed_reg;
	bau_pkg::bau_state_e state_reg;
	logic wr_hit;
	logic rd_hit;
	logic addr_match;
	logic sw_trigger;
	logic [31:0] rdata_next;
	logic break_event;
	logic return_event;
	logic opcode_hit;

	// Writes commit at the edge where waitrequest is sampled low
	assign wr_hit = i_avs_write && ack_reg && i_avs_byteenable[0];
	assign rd_hit = i_avs_read && !ack_reg;
	assign sw_trigger = wr_hit && i_avs_address == bau_pkg::OFF_STATUS_CONTROL
		&& i_avs_writedata[bau_pkg::BIT_ACTIVE];
	// Compare against live registers, program-counter cycles only, not in low power
	assign addr_match = enable_reg && armed_reg && i_cpu_pc_fetch && !i_cpu_low_power
		&& i_cpu_addr == {addr_high_reg, addr_low_reg};
	assign break_event = state_reg != bau_pkg::ST_BREAK && (addr_match || sw_trigger);
	assign return_event = state_reg == bau_pkg::ST_BREAK && i_cpu_rti;
	// Opcode match forces at once; a software write in the same cycle defers to the boundary
	assign opcode_hit = addr_match && i_cpu_opcode_fetch && !sw_trigger;

	// One wait cycle then acknowledge
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_reg);
		end
	end

	always_comb begin
		rdata_next = bau_pkg::UNMAPPED_READ;
		case (i_avs_address)
			bau_pkg::OFF_STATUS_CONTROL: begin
				rdata_next[bau_pkg::BIT_ENABLE] = enable_reg;
				rdata_next[bau_pkg::BIT_ACTIVE] = active_reg;
			end
			bau_pkg::OFF_ADDR_HIGH: rdata_next[7:0] = addr_high_reg;
			bau_pkg::OFF_ADDR_LOW: rdata_next[7:0] = addr_low_reg;
			bau_pkg::OFF_AUXILIARY: rdata_next[bau_pkg::BIT_WDOG_OFF] = wdog_off_reg;
			bau_pkg::OFF_WAIT_STATUS: rdata_next[bau_pkg::BIT_WAIT_EXIT] = wait_exit_reg;
			bau_pkg::OFF_FLAG_CONTROL: rdata_next[bau_pkg::BIT_FLAG_CLEAR] = flag_clear_reg;
			bau_pkg::OFF_IRQ_STATUS: rdata_next[1:0] = irq_status_reg;
			bau_pkg::OFF_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
			default: rdata_next = bau_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_avs_readdata <= bau_pkg::UNMAPPED_READ;
		end else if (rd_hit) begin
			o_avs_readdata <= rdata_next;
		end
	end

	// Address registers clear at reset
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			addr_high_reg <= bau_pkg::RESET_BYTE;
			addr_low_reg <= bau_pkg::RESET_BYTE;
		end else if (wr_hit) begin
			if (i_avs_address == bau_pkg::OFF_ADDR_HIGH) begin
				addr_high_reg <= i_avs_writedata[7:0];
			end
			if (i_avs_address == bau_pkg::OFF_ADDR_LOW) begin
				addr_low_reg <= i_avs_writedata[7:0];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			enable_reg <= 1'b0;
			wdog_off_reg <= 1'b0;
			flag_clear_reg <= 1'b0;
		end else if (wr_hit) begin
			if (i_avs_address == bau_pkg::OFF_STATUS_CONTROL) begin
				enable_reg <= i_avs_writedata[bau_pkg::BIT_ENABLE];
			end
			if (i_avs_address == bau_pkg::OFF_AUXILIARY) begin
				wdog_off_reg <= i_avs_writedata[bau_pkg::BIT_WDOG_OFF];
			end
			if (i_avs_address == bau_pkg::OFF_FLAG_CONTROL) begin
				flag_clear_reg <= i_avs_writedata[bau_pkg::BIT_FLAG_CLEAR];
			end
		end
	end

	// Active bit: hardware set wins over software clear
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			active_reg <= 1'b0;
		end else if (addr_match || sw_trigger) begin
			active_reg <= 1'b1;
		end else if (wr_hit && i_avs_address == bau_pkg::OFF_STATUS_CONTROL) begin
			active_reg <= 1'b0;
		end
	end

	// Clearing active without a new address leaves the unit disarmed
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			armed_reg <= 1'b1;
		end else if (wr_hit && (i_avs_address == bau_pkg::OFF_ADDR_HIGH
			|| i_avs_address == bau_pkg::OFF_ADDR_LOW)) begin
			armed_reg <= 1'b1;
		end else if (addr_match) begin
			armed_reg <= 1'b0;
		end
	end

	// Run, pending until instruction boundary, break until return
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= bau_pkg::ST_RUN;
		end else begin
			case (state_reg)
				bau_pkg::ST_RUN: begin
					if (opcode_hit) begin
						state_reg <= bau_pkg::ST_BREAK;
					end else if (addr_match || sw_trigger) begin
						state_reg <= bau_pkg::ST_PENDING;
					end
				end
				bau_pkg::ST_PENDING: begin
					if (i_cpu_instr_start) begin
						state_reg <= bau_pkg::ST_BREAK;
					end
				end
				bau_pkg::ST_BREAK: begin
					if (i_cpu_rti) begin
						state_reg <= bau_pkg::ST_RUN;
					end
				end
				default: state_reg <= bau_pkg::ST_RUN;
			endcase
		end
	end

	// Opcode matches replace the fetched opcode; operand matches wait for the next boundary
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_breakpoint_request <= 1'b0;
			o_force_opcode <= 1'b0;
		end else begin
			o_breakpoint_request <= state_reg == bau_pkg::ST_PENDING
				|| (state_reg == bau_pkg::ST_RUN && (addr_match || sw_trigger));
			o_force_opcode <= (state_reg == bau_pkg::ST_RUN && opcode_hit)
				|| (state_reg == bau_pkg::ST_PENDING && i_cpu_instr_start);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_opcode <= bau_pkg::SWI_OPCODE;
			o_vector <= bau_pkg::VEC_NORMAL;
		end else begin
			o_opcode <= bau_pkg::SWI_OPCODE;
			o_vector <= i_monitor_rom ? bau_pkg::VEC_MONITOR : bau_pkg::VEC_NORMAL;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_break_state <= 1'b0;
			o_timer_freeze <= 1'b0;
			o_watchdog_off <= 1'b0;
			o_flag_clear_ok <= 1'b1;
		end else begin
			o_break_state <= state_reg == bau_pkg::ST_BREAK && !i_cpu_rti;
			o_timer_freeze <= state_reg == bau_pkg::ST_BREAK && !i_cpu_rti;
			o_watchdog_off <= state_reg == bau_pkg::ST_BREAK && !i_cpu_rti
				&& i_monitor_rom && wdog_off_reg;
			o_flag_clear_ok <= state_reg != bau_pkg::ST_BREAK || i_cpu_rti || flag_clear_reg;
		end
	end

	// Wait exit flag: set when a break wakes the CPU, cleared on return
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_exit_reg <= 1'b0;
		end else if (i_cpu_wait_wake && (state_reg == bau_pkg::ST_PENDING || sw_trigger)) begin
			wait_exit_reg <= 1'b1;
		end else if (return_event) begin
			wait_exit_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_status_reg <= 2'h0;
			irq_mask_reg <= 2'h0;
		end else begin
			if (wr_hit && i_avs_address == bau_pkg::OFF_IRQ_MASK) begin
				irq_mask_reg <= i_avs_writedata[1:0];
			end
			irq_status_reg <= (irq_status_reg & ~((wr_hit && i_avs_address == bau_pkg::OFF_IRQ_STATUS)
				? i_avs_writedata[1:0] : 2'h0)) | {return_event, break_event};
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	enable_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!enable_reg |-> !addr_match) else $error("match while disabled");
	low_power_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		i_cpu_low_power && !sw_trigger && state_reg == bau_pkg::ST_RUN |=> state_reg == bau_pkg::ST_RUN)
		else $error("break in low power");
	request_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_RUN && addr_match |=> o_breakpoint_request && active_reg)
		else $error("no request on match");
	sw_break_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_RUN && sw_trigger |=> state_reg == bau_pkg::ST_PENDING)
		else $error("software break lost");
	boundary_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_PENDING && i_cpu_instr_start |=> o_force_opcode ##0 state_reg == bau_pkg::ST_BREAK)
		else $error("break not at boundary");
	return_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		return_event |=> state_reg == bau_pkg::ST_RUN ##0 !o_timer_freeze) else $error("return ignored");
	disarm_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		addr_match |=> !armed_reg) else $error("not disarmed");
	freeze_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_BREAK && !i_cpu_rti |=> o_timer_freeze) else $error("timer not frozen");
	vector_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		i_monitor_rom |=> o_vector == bau_pkg::VEC_MONITOR) else $error("wrong vector");
	wdog_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!wdog_off_reg |=> !o_watchdog_off) else $error("watchdog off without bit");
	flag_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_BREAK && !i_cpu_rti && !flag_clear_reg |=> !o_flag_clear_ok)
		else $error("flags clearable in break");
	opcode_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_RUN && opcode_hit |=> o_force_opcode && state_reg == bau_pkg::ST_BREAK)
		else $error("opcode match not forced");
	operand_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_RUN && addr_match && !i_cpu_opcode_fetch |=> !o_force_opcode && state_reg == bau_pkg::ST_PENDING)
		else $error("operand match forced early");
	wait_exit_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		i_cpu_wait_wake && state_reg == bau_pkg::ST_PENDING |=> wait_exit_reg)
		else $error("wait exit not flagged");
	sw_request_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg == bau_pkg::ST_RUN && sw_trigger |=> o_breakpoint_request && active_reg)
		else $error("software break not requested");
	flag_free_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_reg != bau_pkg::ST_BREAK |=> o_flag_clear_ok)
		else $error("flags blocked outside break");
	watchdog_mon_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!i_monitor_rom |=> !o_watchdog_off)
		else $error("watchdog off outside monitor");
	addr_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!wr_hit |=> $stable({addr_high_reg, addr_low_reg}))
		else $error("address changed without write");
	bus_ready_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	irq_level_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		|(irq_status_reg & irq_mask_reg) |=> o_irq)
		else $error("interrupt not raised");

	addr_break_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
		addr_match && i_cpu_opcode_fetch ##1 o_force_opcode);
	sw_break_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
		sw_trigger ##[1:20] state_reg == bau_pkg::ST_BREAK);
	return_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn) return_event ##1 o_irq);
	operand_break_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
		addr_match && !i_cpu_opcode_fetch ##1 state_reg == bau_pkg::ST_PENDING ##[1:4] o_force_opcode);
	wait_exit_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn) i_cpu_wait_wake ##1 wait_exit_reg);
endmodule : bau_core

// File: bau_cpu_model.sv
// Purpose: CPU core and integration side model for the breakpoint unit
// Assumes: Same clock as the unit; fetches are driven one per task call
// Notes: Address bus shows the inverse of the last address between fetches
`timescale 1ns/1ns
module bau_cpu_model (
	input wire logic i_core_clk, // Bus clock
	output logic [15:0] o_addr, // CPU address bus
	output logic o_pc_fetch, // Address from program counter
	output logic o_opcode_fetch, // Fetch is an opcode
	output logic o_instr_start, // Instruction boundary pulse
	output logic o_return, // Return-from-interrupt pulse
	output logic o_low_power, // Wait or stop mode
	output logic o_wait_wake, // Leaving wait pulse
	output logic o_monitor // Monitor mode
);
	initial begin
		o_addr = 16'h0000;
		o_pc_fetch = 1'b0;
		o_opcode_fetch = 1'b0;
		o_instr_start = 1'b0;
		o_return = 1'b0;
		o_low_power = 1'b0;
		o_wait_wake = 1'b0;
		o_monitor = 1'b0;
	end

	// One fetch cycle, then the next instruction boundary
	task fetch(input logic [15:0] a, input logic pc, input logic opc);
		@(posedge i_core_clk);
		o_addr <= a;
		o_pc_fetch <= pc;
		o_opcode_fetch <= opc;
		@(posedge i_core_clk);
		o_addr <= ~a;
		o_pc_fetch <= 1'b0;
		o_opcode_fetch <= 1'b0;
		o_instr_start <= 1'b1;
		@(posedge i_core_clk);
		o_instr_start <= 1'b0;
	endtask : fetch

	// Return instruction closes the break routine
	task ret();
		@(posedge i_core_clk);
		o_return <= 1'b1;
		@(posedge i_core_clk);
		o_return <= 1'b0;
	endtask : ret

	// Wait mode left while a break is pending
	task wake_up();
		@(posedge i_core_clk);
		o_wait_wake <= 1'b1;
		@(posedge i_core_clk);
		o_wait_wake <= 1'b0;
	endtask : wake_up

	// Level inputs change together, just after an edge
	task set_mode(input logic mon, input logic lp);
		o_monitor <= mon;
		o_low_power <= lp;
	endtask : set_mode
endmodule : bau_cpu_model

// File: test_breakpoint_address_unit.sv
// Purpose: Self-checking bench for the breakpoint address unit
// Assumes: Avalon-MM answer one cycle after a request is seen
// Notes: Reads and break entries are noted in one queue, checked by a watcher
`timescale 1ns/1ns
module test_breakpoint_address_unit;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [4:0] i_avs_address = 5'h00;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0] i_avs_byteenable = 4'hf;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest, o_breakpoint_request, o_force_opcode, o_break_state, o_timer_freeze;
	logic o_watchdog_off, o_flag_clear_ok, o_irq, pc, opc, lp, ret, wake, mon, start;
	logic [7:0] o_opcode;
	logic [15:0] o_vector, cpu_addr, a;
	logic [31:0] exp_q[$];
	int mismatches = 0;
	int comparisons = 0;
	int seed = 45431;

	always #5 i_core_clk = ~i_core_clk;

	bau_cpu_model i_cpu (.i_core_clk(i_core_clk), .o_addr(cpu_addr), .o_pc_fetch(pc), .o_opcode_fetch(opc),
		.o_instr_start(start), .o_return(ret), .o_low_power(lp), .o_wait_wake(wake), .o_monitor(mon));

	bau_core i_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_cpu_addr(cpu_addr), .i_cpu_pc_fetch(pc), .i_cpu_opcode_fetch(opc), .i_cpu_instr_start(start),
		.i_cpu_rti(ret), .i_cpu_low_power(lp), .i_cpu_wait_wake(wake), .i_monitor_rom(mon),
		.o_breakpoint_request(o_breakpoint_request), .o_force_opcode(o_force_opcode), .o_opcode(o_opcode),
		.o_vector(o_vector), .o_break_state(o_break_state), .o_timer_freeze(o_timer_freeze),
		.o_watchdog_off(o_watchdog_off), .o_flag_clear_ok(o_flag_clear_ok), .o_irq(o_irq));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check

	task finish_test();
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	task bus(input logic wr, input logic [4:0] adr, input logic [7:0] d);
		@(posedge i_core_clk);
		i_avs_read <= ~wr;
		i_avs_write <= wr;
		i_avs_address <= adr;
		i_avs_writedata <= {24'h0, d};
		@(posedge i_core_clk);
		while (o_avs_waitrequest) @(posedge i_core_clk);
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus

	task rd(input logic [4:0] adr, input logic [7:0] d);
		exp_q.push_back({24'h0, d});
		bus(1'b0, adr, d);
	endtask : rd

	task note_break(input logic [15:0] vec);
		exp_q.push_back({8'h00, bau_pkg::SWI_OPCODE, vec});
	endtask : note_break

	task settle();
		repeat (2) @(posedge i_core_clk);
	endtask : settle

	// Watcher: every read answer and every forced opcode takes the oldest note
	always @(posedge i_core_clk) begin
		if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
			check(o_avs_readdata, exp_q.size() ? exp_q.pop_front() : 32'hdead_beef);
		end
		if (o_force_opcode === 1'b1) begin
			check({8'h00, o_opcode, o_vector}, exp_q.size() ? exp_q.pop_front() : 32'hdead_beef);
		end
	end

	initial begin
		repeat (20000) @(posedge i_core_clk);
		mismatches++;
		finish_test();
	end

	initial begin
		repeat (4) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(5'(i * 4), 8'h00);
		rd(5'h02, 8'h00);
		i_avs_byteenable <= 4'h0;
		bus(1'b1, bau_pkg::OFF_ADDR_HIGH, 8'hff);
		i_avs_byteenable <= 4'hf;
		rd(bau_pkg::OFF_ADDR_HIGH, 8'h00);
		bus(1'b1, bau_pkg::OFF_IRQ_MASK, 8'h01);
		a = 16'($random(seed));
		bus(1'b1, bau_pkg::OFF_ADDR_HIGH, a[15:8]);
		bus(1'b1, bau_pkg::OFF_ADDR_LOW, a[7:0]);
		bus(1'b1, bau_pkg::OFF_STATUS_CONTROL, 8'h80);
		rd(bau_pkg::OFF_ADDR_HIGH, a[15:8]);
		rd(bau_pkg::OFF_ADDR_LOW, a[7:0]);
		note_break(bau_pkg::VEC_NORMAL);
		i_cpu.fetch(a, 1'b1, 1'b1);
		settle();
		check(o_timer_freeze, 1'b1);
		check({o_irq, o_flag_clear_ok, o_watchdog_off}, 3'b100);
		rd(bau_pkg::OFF_STATUS_CONTROL, 8'hc0);
		bus(1'b1, bau_pkg::OFF_STATUS_CONTROL, 8'h80);
		i_cpu.ret();
		settle();
		check({o_break_state, o_timer_freeze}, 2'b00);
		i_cpu.fetch(a, 1'b1, 1'b1);
		settle();
		check(o_breakpoint_request, 1'b0);
		rd(bau_pkg::OFF_IRQ_STATUS, 8'h03);
		bus(1'b1, bau_pkg::OFF_IRQ_STATUS, 8'h03);
		settle();
		check(o_irq, 1'b0);
		// New address for a second break, this time on an operand in monitor mode
		a = 16'($random(seed));
		bus(1'b1, bau_pkg::OFF_ADDR_HIGH, a[15:8]);
		bus(1'b1, bau_pkg::OFF_ADDR_LOW, a[7:0]);
		bus(1'b1, bau_pkg::OFF_AUXILIARY, 8'h01);
		bus(1'b1, bau_pkg::OFF_FLAG_CONTROL, 8'h80);
		i_cpu.set_mode(1'b1, 1'b0);
		note_break(bau_pkg::VEC_MONITOR);
		i_cpu.fetch(a, 1'b1, 1'b0);
		settle();
		check({o_break_state, o_watchdog_off, o_flag_clear_ok}, 3'b111);
		bus(1'b1, bau_pkg::OFF_STATUS_CONTROL, 8'h80);
		i_cpu.ret();
		i_cpu.set_mode(1'b0, 1'b0);
		bus(1'b1, bau_pkg::OFF_IRQ_MASK, 8'h00);
		bus(1'b1, bau_pkg::OFF_STATUS_CONTROL, 8'hc0);
		settle();
		check(o_break_state, 1'b0);
		i_cpu.wake_up();
		note_break(bau_pkg::VEC_NORMAL);
		i_cpu.fetch(~a, 1'b1, 1'b1);
		settle();
		check({o_break_state, o_irq}, 2'b10);
		rd(bau_pkg::OFF_WAIT_STATUS, 8'h02);
		bus(1'b1, bau_pkg::OFF_STATUS_CONTROL, 8'h80);
		i_cpu.ret();
		rd(bau_pkg::OFF_WAIT_STATUS, 8'h00);
		// Disabled, data-side address, and low power: none may break
		for (int k = 0; k < 3; k++) begin
			a = 16'($random(seed));
			bus(1'b1, bau_pkg::OFF_ADDR_HIGH, a[15:8]);
			bus(1'b1, bau_pkg::OFF_ADDR_LOW, a[7:0]);
			bus(1'b1, bau_pkg::OFF_STATUS_CONTROL, (k == 0) ? 8'h00 : 8'h80);
			i_cpu.set_mode(1'b0, k == 2);
			i_cpu.fetch(a, k != 1, 1'b1);
			settle();
			check(o_breakpoint_request, 1'b0);
		end
		i_cpu.set_mode(1'b0, 1'b0);
		settle();
		check(exp_q.size(), 0);
		finish_test();
	end
endmodule : test_breakpoint_address_unit
